// *** design/sse_ctx_mem.sv ***
// Per-channel context memory with registered read data
`default_nettype none
module sse_ctx_mem
   import sse_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 we,
   input  wire logic [SSE_CH_W-1:0]  waddr,
   input  wire logic [SSE_MEM_W-1:0] wdata,
   input  wire logic [SSE_CH_W-1:0]  raddr,
   output logic      [SSE_MEM_W-1:0] rdata
);
   logic [SSE_MEM_W-1:0] mem [SSE_CHANNELS];

   // No reset: software initialises every context before use
   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // sse_ctx_mem
`default_nettype wire

// *** design/sse_energy_ctx.sv ***
// Silence suppression energy context engine with register port
`default_nettype none
// Operation
// - Each channel keeps a talk flag, 0 while suppressing and 1 while not.
// - Each channel stores the last sent comfort noise energy exactly as sent.
// - A per-channel accumulator sums frame energies; software clears it before activation.
// - A per-channel period counter runs from zero to the first, then the subsequent, period.
// - At terminal count a noise level is averaged; it is stored only when it is sent.
// - The period counter clears on a non-silent frame; software zeroes it at init.
// - A free-running 16-bit wrapping counter counts underruns on the adjacent stream.
// - Select bit clear pairs stream zero with one; set pairs zero with two.
// - A refresh is sent only if the change is at least the threshold in dB.
// - The period values give the frame count averaged at onset and for refreshes.
module sse_energy_ctx
   import sse_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic [7:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [31:0]             rdata,
   input  wire logic                    frame_valid,
   output logic                         frame_ready,
   input  wire logic [SSE_CH_W-1:0]     frame_ch,
   input  wire logic                    frame_silent,
   input  wire logic [SSE_DB_W-1:0]     frame_energy,
   input  wire logic                    underrun,
   input  wire logic [SSE_STREAM_W-1:0] underrun_stream,
   output logic                         cn_send,
   output logic      [SSE_CH_W-1:0]     cn_ch,
   output logic      [SSE_DB_W-1:0]     cn_energy
);
   typedef struct packed {
      sse_state_t                 st;
      logic                       adj_sel;
      logic [SSE_DB_W-1:0]        thr;
      logic [SSE_PER_W-1:0]       first_per;
      logic [SSE_PER_W-1:0]       subs_per;
      logic [SSE_CH_W-1:0]        chsel;
      logic [SSE_CH_W-1:0]        ch;
      logic                       silent;
      logic [SSE_DB_W-1:0]        energy;
      logic [SSE_UNDER_W-1:0]     under;
      logic [31:0]                rdata;
      logic                       send;
      logic [SSE_CH_W-1:0]        cn_ch;
      logic [SSE_DB_W-1:0]        cn_energy;
      logic                       sw_sum;
      logic [31:0]                sw_word;
      logic                       fwd;
      logic [SSE_MEM_W-1:0]       fwd_word;
   } sse_regs_t;

   sse_regs_t s_q;
   sse_regs_t s_d;

   logic                 mem_we;
   logic [SSE_CH_W-1:0]  mem_waddr;
   logic [SSE_MEM_W-1:0] mem_wdata;
   logic [SSE_CH_W-1:0]  mem_raddr;
   logic [SSE_MEM_W-1:0] mem_rdata;

   logic                 c_cts;
   logic [SSE_DB_W-1:0]  c_lat;
   logic [SSE_SUM_W-1:0] c_sum;
   logic [SSE_PER_W-1:0] c_cnt;
   logic                 c_subs;
   logic                 n_cts;
   logic [SSE_DB_W-1:0]  n_lat;
   logic [SSE_SUM_W-1:0] n_sum;
   logic [SSE_PER_W-1:0] n_cnt;
   logic                 n_subs;
   logic [SSE_PER_W-1:0] term;
   logic [SSE_SUM_W-1:0] avg;
   logic [SSE_DB_W-1:0]  new_db;
   logic [SSE_DB_W-1:0]  diff;
   logic                 sw_ctx_wr;
   logic                 sw_sum_wr;
   logic                 sw_ctx_rd;
   logic                 under_hit;
   logic                 under_load;
   logic [SSE_MEM_W-1:0] ctx_word;

   assign ctx_word    = s_q.fwd ? s_q.fwd_word : mem_rdata;
   assign {c_cts, c_lat, c_sum, c_cnt, c_subs} = ctx_word;
   assign sw_ctx_wr   = wr && (addr == SSE_REG_CTX);
   assign sw_sum_wr   = wr && (addr == SSE_REG_SUM);
   assign sw_ctx_rd   = rd && ((addr == SSE_REG_CTX) || (addr == SSE_REG_SUM));
   assign under_hit   = underrun && (underrun_stream == (s_q.adj_sel ? SSE_STREAM_TWO : SSE_STREAM_ONE));
   assign under_load  = wr && (addr == SSE_REG_UNDER);
   // Software context accesses take the port; the frame waits a cycle
   assign frame_ready = !sw_ctx_wr && !sw_sum_wr && !sw_ctx_rd;

   sse_ctx_mem u_mem (
      .clock (clock),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   always_comb
   begin
      s_d       = s_q;
      s_d.send  = 1'b0;
      mem_we    = 1'b0;
      mem_waddr = s_q.ch;
      mem_wdata = mem_rdata;
      mem_raddr = frame_ready ? frame_ch : s_q.chsel;
      n_cts     = c_cts;
      n_lat     = c_lat;
      n_sum     = c_sum;
      n_cnt     = c_cnt;
      n_subs    = c_subs;
      term      = c_subs ? s_q.subs_per : s_q.first_per;
      avg       = '0;
      new_db    = '0;
      diff      = '0;

      // Wraps by width, never saturates
      if (under_hit)
      begin
         s_d.under = s_q.under + 16'h0001;
      end

      if (wr)
      begin
         if (addr == SSE_REG_CTRL)
         begin
            s_d.adj_sel = wdata[SSE_CTRL_ADJ_BIT];
            s_d.thr    = wdata[SSE_CTRL_THR_LSB +: SSE_DB_W];
         end
         else if (addr == SSE_REG_PERIODS)
         begin
            s_d.first_per = wdata[SSE_PER_W-1:0];
            s_d.subs_per  = wdata[SSE_PER_SUB_LSB +: SSE_PER_W];
         end
         else if (addr == SSE_REG_CHSEL)
         begin
            s_d.chsel = wdata[SSE_CH_W-1:0];
         end
         else if (addr == SSE_REG_UNDER)
         begin
            s_d.under = wdata[SSE_UNDER_W-1:0];
         end
      end

      if (rd)
      begin
         if (addr == SSE_REG_CTRL)
         begin
            s_d.rdata = {16'h0000, s_q.thr, 7'h00, s_q.adj_sel};
         end
         else if (addr == SSE_REG_PERIODS)
         begin
            s_d.rdata = {16'h0000, s_q.subs_per, s_q.first_per};
         end
         else if (addr == SSE_REG_CHSEL)
         begin
            s_d.rdata = {28'h0000000, s_q.chsel};
         end
         else if (addr == SSE_REG_UNDER)
         begin
            s_d.rdata = {16'h0000, s_q.under};
         end
         else
         begin
            s_d.rdata = 32'h00000000;
         end
      end

      // Issue: one context access a cycle; software wins since it never waits
      if (sw_ctx_wr || sw_sum_wr)
      begin
         s_d.st      = SSE_SWWR;
         s_d.ch      = s_q.chsel;
         s_d.sw_sum  = sw_sum_wr;
         s_d.sw_word = wdata;
      end
      else if (sw_ctx_rd)
      begin
         s_d.st     = SSE_SWRD;
         s_d.sw_sum = (addr == SSE_REG_SUM);
      end
      else if (frame_valid)
      begin
         s_d.st     = SSE_FRAME;
         s_d.ch     = frame_ch;
         s_d.silent = frame_silent;
         s_d.energy = frame_energy;
      end
      else
      begin
         s_d.st = SSE_IDLE;
      end

      // Complete: the context word of last cycle's access is here now
      case (s_q.st)
         SSE_FRAME:
         begin
            begin
               mem_we = 1'b1;
               if (!s_q.silent)
               begin
                  n_cts  = 1'b1;
                  n_cnt  = '0;
                  n_sum  = '0;
                  n_subs = 1'b0;
               end
               else
               begin
                  n_cts = 1'b0;
                  n_sum = c_sum + {16'h0000, s_q.energy};
                  n_cnt = c_cnt + 8'h01;
                  if (n_cnt >= term)
                  begin
                     avg    = n_sum / {16'h0000, (term == 8'h00) ? 8'h01 : term};
                     new_db = avg[SSE_DB_W-1:0];
                     diff   = (new_db > c_lat) ? (new_db - c_lat) : (c_lat - new_db);
                     n_cnt  = '0;
                     n_sum  = '0;
                     n_subs = 1'b1;
                     if (!c_subs || ((s_q.thr != SSE_THR_NEVER) && (diff >= s_q.thr)))
                     begin
                        n_lat       = new_db;
                        s_d.send    = 1'b1;
                        s_d.cn_ch   = s_q.ch;
                        s_d.cn_energy = new_db;
                     end
                  end
               end
               mem_wdata = {n_cts, n_lat, n_sum, n_cnt, n_subs};
            end
         end
         SSE_SWWR:
         begin
            // Read-modify-write: a context write keeps the sum, a sum write the rest
            mem_we = 1'b1;
            if (s_q.sw_sum)
            begin
               mem_wdata = {c_cts, c_lat, s_q.sw_word[SSE_SUM_W-1:0], c_cnt, c_subs};
            end
            else
            begin
               mem_wdata = {s_q.sw_word[SSE_CTX_CTS_BIT], s_q.sw_word[SSE_CTX_LAT_LSB +: SSE_DB_W], c_sum,
                            s_q.sw_word[SSE_CTX_CNT_LSB +: SSE_PER_W], s_q.sw_word[SSE_CTX_SUB_BIT]};
            end
         end
         default:
         begin
            mem_we = 1'b0;
         end
      endcase
      // Memory reads the old word on a same-address write, so forward it
      s_d.fwd      = mem_we && (mem_waddr == mem_raddr);
      s_d.fwd_word = mem_wdata;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         s_q <= '{st: SSE_IDLE, thr: SSE_THR_RST, first_per: SSE_FIRST_RST, subs_per: SSE_SUBS_RST, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   a_ready_sw_first: assert property (@(posedge clock) disable iff (!nrst)
      (sw_ctx_wr || sw_sum_wr || sw_ctx_rd) |-> !frame_ready) else $error("frame taken beside a context access");
   a_under_adjacent: assert property (@(posedge clock) disable iff (!nrst)
      (under_hit && !under_load) |=> (s_q.under == $past(s_q.under) + 16'h0001)) else $error("underrun not counted");
   a_under_other: assert property (@(posedge clock) disable iff (!nrst)
      (!under_hit && !under_load) |=> $stable(s_q.under)) else $error("underrun counter moved");
   a_talk_on_voice: assert property (@(posedge clock) disable iff (!nrst)
      (s_q.st == SSE_FRAME) |-> (mem_we && (mem_wdata[SSE_MEM_W-1] == !s_q.silent))) else $error("talk flag wrong");
   a_count_clear: assert property (@(posedge clock) disable iff (!nrst)
      (s_q.st == SSE_FRAME && !s_q.silent) |-> (n_cnt == 8'h00)) else $error("period count not cleared");
   a_period_bound: assert property (@(posedge clock) disable iff (!nrst)
      (s_q.st == SSE_FRAME && s_q.silent) |-> (n_cnt < term || term == 8'h00)) else $error("period count past end");
   a_refresh_thresh: assert property (@(posedge clock) disable iff (!nrst)
      (s_d.send && c_subs) |-> (diff >= s_q.thr && s_q.thr != SSE_THR_NEVER)) else $error("refresh below threshold");
   a_latch_sent: assert property (@(posedge clock) disable iff (!nrst)
      s_d.send |-> (mem_we && n_lat == new_db)) else $error("sent energy not latched");
   c_onset_sent: cover property (@(posedge clock) disable iff (!nrst) s_d.send && !c_subs);
   c_refresh_sent: cover property (@(posedge clock) disable iff (!nrst) s_d.send && c_subs);
   c_fwd_used: cover property (@(posedge clock) disable iff (!nrst) s_q.fwd && s_q.st != SSE_IDLE);
   c_under_counted: cover property (@(posedge clock) disable iff (!nrst) under_hit);

   // Context reads come from the memory's output register, or from the forwarded word after a same-address write
   assign rdata     = (s_q.st != SSE_SWRD) ? s_q.rdata :
                      s_q.sw_sum ? {8'h00, c_sum} : {7'h00, c_subs, c_cnt, c_lat, 7'h00, c_cts};
   assign cn_send   = s_q.send;
   assign cn_ch     = s_q.cn_ch;
   assign cn_energy = s_q.cn_energy;
endmodule // sse_energy_ctx
`default_nettype wire

// *** design/sse_pkg.sv ***
// Package: constants and types for the silence suppression energy context
`default_nettype none
package sse_pkg;
   localparam int unsigned SSE_CHANNELS    = 16;
   localparam int unsigned SSE_CH_W        = 4;
   localparam int unsigned SSE_DB_W        = 8;
   localparam int unsigned SSE_SUM_W       = 24;
   localparam int unsigned SSE_PER_W       = 8;
   localparam int unsigned SSE_UNDER_W     = 16;
   localparam int unsigned SSE_STREAM_W    = 2;
   localparam int unsigned SSE_MEM_W       = 1 + SSE_DB_W + SSE_SUM_W + SSE_PER_W + 1;

   // Register byte addresses
   localparam logic [7:0] SSE_REG_CTRL     = 8'h00;
   localparam logic [7:0] SSE_REG_PERIODS  = 8'h04;
   localparam logic [7:0] SSE_REG_CHSEL    = 8'h08;
   localparam logic [7:0] SSE_REG_CTX      = 8'h0C;
   localparam logic [7:0] SSE_REG_SUM      = 8'h10;
   localparam logic [7:0] SSE_REG_UNDER    = 8'h14;

   // Field positions
   localparam int unsigned SSE_CTRL_ADJ_BIT = 0;
   localparam int unsigned SSE_CTRL_THR_LSB = 8;
   localparam int unsigned SSE_PER_SUB_LSB  = 8;
   localparam int unsigned SSE_CTX_CTS_BIT  = 0;
   localparam int unsigned SSE_CTX_LAT_LSB  = 8;
   localparam int unsigned SSE_CTX_CNT_LSB  = 16;
   localparam int unsigned SSE_CTX_SUB_BIT  = 24;

   // Reset values and the never-refresh threshold
   localparam logic [SSE_DB_W-1:0]  SSE_THR_RST   = 8'h01;
   localparam logic [SSE_PER_W-1:0] SSE_FIRST_RST = 8'h04;
   localparam logic [SSE_PER_W-1:0] SSE_SUBS_RST  = 8'h10;
   localparam logic [SSE_DB_W-1:0]  SSE_THR_NEVER = 8'h80;

   localparam logic [SSE_STREAM_W-1:0] SSE_STREAM_ZERO = 2'h0;
   localparam logic [SSE_STREAM_W-1:0] SSE_STREAM_ONE  = 2'h1;
   localparam logic [SSE_STREAM_W-1:0] SSE_STREAM_TWO  = 2'h2;

   // State names the context access whose word arrives this cycle
   typedef enum logic [3:0] {
      SSE_IDLE  = 4'b0001,
      SSE_FRAME = 4'b0010,
      SSE_SWRD  = 4'b0100,
      SSE_SWWR  = 4'b1000
   } sse_state_t;
endpackage : sse_pkg
`default_nettype wire

// *** dv/sse_energy_ctx_tb_top.sv ***
// Self-checking testbench for the silence suppression energy context engine
`default_nettype none
`define CHK(nm, ex, gt) \
   begin \
      n_tests++; \
      if ((gt) !== (ex)) \
      begin \
         err_total++; \
         $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
      end \
   end
module sse_energy_ctx_tb_top
   import sse_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                    clock;
   logic                    nrst;
   logic [7:0]              addr;
   logic [31:0]             wdata;
   logic                    wr;
   logic                    rd;
   logic [31:0]             rdata;
   logic                    frame_valid;
   logic                    frame_ready;
   logic [SSE_CH_W-1:0]     frame_ch;
   logic                    frame_silent;
   logic [SSE_DB_W-1:0]     frame_energy;
   logic                    underrun;
   logic [SSE_STREAM_W-1:0] underrun_stream;
   logic                    cn_send;
   logic [SSE_CH_W-1:0]     cn_ch;
   logic [SSE_DB_W-1:0]     cn_energy;
   logic [11:0]             cn_q[$];
   logic [31:0]             rv;
   logic [15:0]             u0;
   int                      err_total = 0;
   int                      n_tests   = 0;
   int                      cyc       = 0;

   sse_energy_ctx dut_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_ch(frame_ch),
      .frame_silent(frame_silent), .frame_energy(frame_energy), .underrun(underrun),
      .underrun_stream(underrun_stream), .cn_send(cn_send), .cn_ch(cn_ch), .cn_energy(cn_energy));

   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Pulse output is only valid in its own cycle, so capture every one
   always @(posedge clock)
   begin
      if (cn_send === 1'b1)
         cn_q.push_back({cn_ch, cn_energy});
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         end_sim();
      end
   end

   task automatic end_sim;
      if (err_total == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask

   // Context read data stands only in the cycle after the strobe; register read data holds until the next read
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Request held until ready is sampled high; bounded wait
   task automatic frames(input logic sil, input logic [7:0] e, input int n);
      int k;
      repeat (n)
      begin
         @(posedge clock);
         frame_valid  <= 1'b1;
         frame_ch     <= 4'h3;
         frame_silent <= sil;
         frame_energy <= e;
         k = 0;
         do
         begin
            @(posedge clock);
            k++;
         end
         while (frame_ready !== 1'b1 && k < 100);
         frame_valid <= 1'b0;
         `CHK("frame accepted", 1'b1, k < 100)
      end
      repeat (8) @(posedge clock);
   endtask

   task automatic expect_cn(input int n, input logic [7:0] e);
      `CHK("cn count", n, cn_q.size())
      if (n > 0 && cn_q.size() > 0)
         `CHK("cn ch and energy", {4'h3, e}, cn_q[$])
      cn_q.delete();
   endtask

   task automatic pulse_under(input logic [1:0] s, input int n);
      repeat (n)
      begin
         @(posedge clock);
         underrun        <= 1'b1;
         underrun_stream <= s;
         @(posedge clock);
         underrun        <= 1'b0;
      end
      repeat (4) @(posedge clock);
   endtask

   initial
   begin
      {nrst, addr, wdata, wr, rd, frame_valid, frame_ch, frame_silent} = '0;
      {frame_energy, underrun, underrun_stream} = '0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      reg_rd(SSE_REG_CTRL, rv);
      `CHK("ctrl reset", {16'h0000, SSE_THR_RST, 8'h00}, rv)
      reg_rd(SSE_REG_PERIODS, rv);
      `CHK("periods reset", {16'h0000, SSE_SUBS_RST, SSE_FIRST_RST}, rv)
      reg_wr(8'h1C, 32'hFFFF_FFFF);
      reg_rd(SSE_REG_CTRL, rv);
      `CHK("ctrl after unmapped write", {16'h0000, SSE_THR_RST, 8'h00}, rv)
      // Short periods keep the run brief; first and subsequent differ on purpose
      reg_wr(SSE_REG_PERIODS, 32'h0000_0302);
      reg_wr(SSE_REG_CHSEL, 32'h0000_0003);
      // Detector presets sit outside this block
      reg_wr(SSE_REG_CTX, 32'h0000_0000);
      reg_wr(SSE_REG_SUM, 32'h0000_0000);
      frames(1'b0, 8'h32, 1);
      reg_rd(SSE_REG_CTX, rv);
      `CHK("talk flag talking", 1'b1, rv[0])
      frames(1'b1, 8'h14, 2);
      expect_cn(1, 8'h14);
      reg_rd(SSE_REG_CTX, rv);
      `CHK("talk flag silent", 1'b0, rv[0])
      `CHK("latched energy", 8'h14, rv[15:8])
      frames(1'b1, 8'h14, 3);
      expect_cn(0, 8'h00);
      frames(1'b1, 8'h17, 2);
      expect_cn(0, 8'h00);
      reg_rd(SSE_REG_CTX, rv);
      `CHK("period count", 8'h02, rv[23:16])
      reg_rd(SSE_REG_SUM, rv);
      `CHK("energy sum", 32'h0000_002E, rv)
      frames(1'b1, 8'h17, 1);
      expect_cn(1, 8'h17);
      reg_wr(SSE_REG_CTRL, 32'h0000_0500);
      frames(1'b1, 8'h14, 3);
      expect_cn(0, 8'h00);
      frames(1'b1, 8'h12, 3);
      expect_cn(1, 8'h12);
      reg_wr(SSE_REG_CTRL, {16'h0000, SSE_THR_NEVER, 8'h00});
      frames(1'b1, 8'h3C, 3);
      expect_cn(0, 8'h00);
      reg_rd(SSE_REG_CTX, rv);
      `CHK("latched energy held", 8'h12, rv[15:8])
      frames(1'b0, 8'h32, 1);
      reg_rd(SSE_REG_CTX, rv);
      `CHK("period cleared", 8'h00, rv[23:16])
      `CHK("talk flag back", 1'b1, rv[0])
      reg_rd(SSE_REG_UNDER, rv);
      u0 = rv[15:0];
      pulse_under(SSE_STREAM_ONE, 2);
      pulse_under(SSE_STREAM_TWO, 1);
      reg_rd(SSE_REG_UNDER, rv);
      `CHK("underrun pair one", u0 + 16'h0002, rv[15:0])
      reg_wr(SSE_REG_CTRL, 32'h0000_0101);
      pulse_under(SSE_STREAM_ONE, 1);
      pulse_under(SSE_STREAM_TWO, 3);
      reg_rd(SSE_REG_UNDER, rv);
      `CHK("underrun pair two", u0 + 16'h0005, rv[15:0])
      end_sim();
   end
endmodule // sse_energy_ctx_tb_top
`default_nettype wire
